// ==== rtl/fsup_top.sv ====
// fault supervisor, power-good qualifier, telemetry and command registers
// Summary of operation
// - startup, severe and safe overcurrent latch, pull alarm low, keep switch off
// - switch short found at self-check latches a fault and pulls alarm low
// - soft-start capacitor discharge failure latches a fault and pulls alarm low
// - address resistor out of range latches a fault and pulls alarm low
// - overcurrent resistor out of range latches a fault and pulls alarm low
// - enable/lockout pin low is non-latching and never pulls alarm low
// - input lockout clears every latched fault and releases the alarm
// - boost lockout before startup latches off silently, no alarm, no status
// - supply ok needs output good, input good, no short, switch fully on
// - supply ok waits 5 ms after switch fully on, others still met
// - power is voltage times current; energy accumulates power samples
// - reported averages use a software-chosen sample count
// - warning averages use their own software-chosen sample count
// - peaks of vin, vout, iout, power and temperature held readable
// - warning flags set when averages cross programmed warning limits
// - startup overcurrent level comes from startup config bits 5:4
// - input overvoltage level from protection config bits 3:2, with enable
// - protection config bits 9:8 choose the output power-good level
// - report count from startup config 3:0, warning count from protection 1:0
// - overtemperature warning and fault limits at 51h and 4Fh
// - overpower warning limit at 6Bh, overpower fault limit at F5h
// - input undervoltage warning and fault limits at 58h and 59h
// - latched faults clear only by lockout toggle or operation restart
// - alarm pin pulled low from outside counts as a latching fault
`timescale 1ns/1ps
module fsup_top #(
    parameter int unsigned PG_DELAY_CYCLES = fsup_pkg::PG_DELAY_MS * fsup_pkg::CLK_KHZ
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic ARST_N,
    // analog detector pins
    input wire logic STARTUP_OCP_DET,
    input wire logic SEVERE_OCP_DET,
    input wire logic SAFE_OCP_DET,
    input wire logic FET_SHORT_DET,
    input wire logic SOFTSTART_CAP_FAIL,
    input wire logic BUS_ADDRESS_RESISTOR_BAD,
    input wire logic OVERCURRENT_SET_RESISTOR_BAD,
    input wire logic BOOST_SUPPLY_LOCKOUT,
    input wire logic INPUT_OVERVOLT_TRIP,
    input wire logic ENABLE_LOCKOUT_PIN,
    input wire logic VOUT_ABOVE_PG,
    input wire logic FET_FULLY_ON,
    // alarm open-drain pin
    input wire logic ALARM_IN,
    output logic ALARM_OUT,
    output logic ALARM_OE_N,
    // supply ok open-drain pin
    output logic SUPPLY_OK_PIN_OUT,
    output logic SUPPLY_OK_PIN_OE_N,
    // pass switch and analog trims
    output logic SWITCH_EN,
    output logic [1:0] STARTUP_OCP_SEL,
    output logic [1:0] OVP_SEL,
    output logic [1:0] PG_THRESH_SEL,
    // converter samples
    input wire logic SAMPLE_VALID,
    input wire logic [15:0] VIN_SAMPLE,
    input wire logic [15:0] VOUT_SAMPLE,
    input wire logic [15:0] IOUT_SAMPLE,
    input wire logic [15:0] TEMP_SAMPLE,
    // command port
    input wire logic [7:0] CMD_CODE,
    input wire logic WR_STB,
    input wire logic [15:0] WR_DATA,
    input wire logic RD_STB,
    output logic [15:0] RD_DATA,
    output logic RD_VALID
);
    import fsup_pkg::*;

    logic [NUM_SI-1:0] pin_raw;
    logic [NUM_SI-1:0] s1_reg, s2_reg, s3_reg, pin_q_reg;
    logic [15:0] uvw_out_reg, ocw_reg, otf_reg, otw_reg, uvw_in_reg;
    logic [15:0] uvf_in_reg, opw_reg, prot_cfg_reg, su_cfg_reg, opf_reg;
    logic [15:0] cause_reg, cause_next, det;
    logic boost_off_reg, boost_off_next, sw_reg, alarm_oe_n_reg, okay_oe_n_reg;
    logic [2:0] amask_reg;
    logic [31:0] pg_cnt_reg;
    logic lockout_ok, restart, clr_warn, clear, ext_alarm, pg, qual;
    logic [31:0] pwr_prod, ein_reg;
    logic [15:0] smp [NUM_CH];
    logic [15:0] ravg_reg [NUM_CH];
    logic [15:0] wavg_reg [NUM_CH];
    logic [15:0] peak_reg [NUM_CH];
    logic [15:0] rep_cnt_reg, rep_last;
    logic [2:0] wrn_cnt_reg, wrn_last;
    logic [3:0] rep_n;
    logic [1:0] wrn_m;
    logic rep_dump, wrn_dump;
    logic [15:0] warn_reg, wcond, status, rd_mux, rd_data_reg;
    logic rd_valid_reg;

    assign pin_raw[SI_SUOCP] = STARTUP_OCP_DET;
    assign pin_raw[SI_SEVOCP] = SEVERE_OCP_DET;
    assign pin_raw[SI_SAFEOCP] = SAFE_OCP_DET;
    assign pin_raw[SI_FETSH] = FET_SHORT_DET;
    assign pin_raw[SI_SSDIS] = SOFTSTART_CAP_FAIL;
    assign pin_raw[SI_ADDRR] = BUS_ADDRESS_RESISTOR_BAD;
    assign pin_raw[SI_OCPR] = OVERCURRENT_SET_RESISTOR_BAD;
    assign pin_raw[SI_BOOST] = BOOST_SUPPLY_LOCKOUT;
    assign pin_raw[SI_OVP] = INPUT_OVERVOLT_TRIP;
    assign pin_raw[SI_ENLO] = ENABLE_LOCKOUT_PIN;
    assign pin_raw[SI_VOUTPG] = VOUT_ABOVE_PG;
    assign pin_raw[SI_FETON] = FET_FULLY_ON;
    assign pin_raw[SI_ALARM] = ALARM_IN;

    // a change is taken once stages two and three agree
    for (genvar g = 0; g < NUM_SI; g++) begin : g_sync
        always_ff @(posedge REF_CLK or negedge ARST_N) begin
            if (!ARST_N) begin
                s1_reg[g] <= PIN_Q_RST[g];
                s2_reg[g] <= PIN_Q_RST[g];
                s3_reg[g] <= PIN_Q_RST[g];
                pin_q_reg[g] <= PIN_Q_RST[g];
            end else begin
                s1_reg[g] <= pin_raw[g];
                s2_reg[g] <= s1_reg[g];
                s3_reg[g] <= s2_reg[g];
                if (s2_reg[g] == s3_reg[g]) begin
                    pin_q_reg[g] <= s3_reg[g];
                end
            end
        end
    end

    assign lockout_ok = pin_q_reg[SI_ENLO];
    assign restart = WR_STB && CMD_CODE == CMD_OPERATION && WR_DATA[OP_RESTART_BIT];
    assign clr_warn = WR_STB && CMD_CODE == CMD_CLEAR_FAULTS;
    // released pin reads high through its pull-up: that is supply ok
    assign pg = okay_oe_n_reg;

    // limit and configuration writes
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            uvw_out_reg <= LIM_LOW_RST;
            ocw_reg <= LIM_HIGH_RST;
            otf_reg <= LIM_HIGH_RST;
            otw_reg <= LIM_HIGH_RST;
            uvw_in_reg <= LIM_LOW_RST;
            uvf_in_reg <= LIM_LOW_RST;
            opw_reg <= LIM_HIGH_RST;
            prot_cfg_reg <= CFG_RST;
            su_cfg_reg <= CFG_RST;
            opf_reg <= LIM_HIGH_RST;
        end else if (WR_STB) begin
            unique case (CMD_CODE)
                CMD_VOUT_UVW: uvw_out_reg <= WR_DATA;
                CMD_IOUT_OCW: ocw_reg <= WR_DATA;
                CMD_TEMP_OTF: otf_reg <= WR_DATA;
                CMD_TEMP_OTW: otw_reg <= WR_DATA;
                CMD_VIN_UVW: uvw_in_reg <= WR_DATA;
                CMD_VIN_UVF: uvf_in_reg <= WR_DATA;
                CMD_PIN_OPW: opw_reg <= WR_DATA;
                CMD_PROT_CFG: prot_cfg_reg <= WR_DATA;
                CMD_SU_CFG: su_cfg_reg <= WR_DATA;
                CMD_PIN_OPF: opf_reg <= WR_DATA;
                default: ;
            endcase
        end
    end

    assign STARTUP_OCP_SEL = su_cfg_reg[SC_SUOCP_LSB +: 2];
    assign OVP_SEL = prot_cfg_reg[PC_OVP_SEL_LSB +: 2];
    assign PG_THRESH_SEL = prot_cfg_reg[PC_PG_SEL_LSB +: 2];

    // telemetry sampling
    assign pwr_prod = {16'h0000, VIN_SAMPLE} * {16'h0000, IOUT_SAMPLE};
    assign smp[CH_VIN] = VIN_SAMPLE;
    assign smp[CH_VOUT] = VOUT_SAMPLE;
    assign smp[CH_IOUT] = IOUT_SAMPLE;
    assign smp[CH_PIN] = pwr_prod[31:16];
    assign smp[CH_TEMP] = TEMP_SAMPLE;

    assign rep_n = su_cfg_reg[SC_RAVG_LSB +: 4];
    assign wrn_m = prot_cfg_reg[PC_WAVG_LSB +: 2];
    assign rep_last = (16'h1 << rep_n) - 16'h1;
    assign wrn_last = 3'((4'h1 << wrn_m) - 4'h1);
    // >= so a smaller count written mid-window dumps at once
    assign rep_dump = SAMPLE_VALID && rep_cnt_reg >= rep_last;
    assign wrn_dump = SAMPLE_VALID && wrn_cnt_reg >= wrn_last;

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rep_cnt_reg <= 16'h0000;
            wrn_cnt_reg <= 3'h0;
        end else if (SAMPLE_VALID) begin
            rep_cnt_reg <= rep_dump ? 16'h0000 : rep_cnt_reg + 16'h0001;
            wrn_cnt_reg <= wrn_dump ? 3'h0 : wrn_cnt_reg + 3'h1;
        end
    end

    // accumulate-and-dump per channel; temperature shares the scheme
    for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
        logic [31:0] racc_reg, rsum;
        logic [18:0] wacc_reg, wsum;
        assign rsum = racc_reg + {16'h0000, smp[c]};
        assign wsum = wacc_reg + {3'h0, smp[c]};
        always_ff @(posedge REF_CLK or negedge ARST_N) begin
            if (!ARST_N) begin
                racc_reg <= 32'h0;
                wacc_reg <= 19'h0;
                ravg_reg[c] <= 16'h0000;
                wavg_reg[c] <= 16'h0000;
            end else if (SAMPLE_VALID) begin
                if (rep_dump) begin
                    ravg_reg[c] <= 16'(rsum >> rep_n);
                    racc_reg <= 32'h0;
                end else begin
                    racc_reg <= rsum;
                end
                if (wrn_dump) begin
                    wavg_reg[c] <= 16'(wsum >> wrn_m);
                    wacc_reg <= 19'h0;
                end else begin
                    wacc_reg <= wsum;
                end
            end
        end
        always_ff @(posedge REF_CLK or negedge ARST_N) begin
            if (!ARST_N) begin
                peak_reg[c] <= 16'h0000;
            end else if (SAMPLE_VALID && smp[c] > peak_reg[c]) begin
                peak_reg[c] <= smp[c];
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ein_reg <= 32'h0;
        end else if (SAMPLE_VALID) begin
            ein_reg <= ein_reg + {16'h0000, smp[CH_PIN]};
        end
    end

    // warnings on the warning averages; set wins over clear
    always_comb begin
        wcond = 16'h0000;
        wcond[WB_VIN_UVW] = wavg_reg[CH_VIN] < uvw_in_reg;
        wcond[WB_VIN_UVF] = wavg_reg[CH_VIN] < uvf_in_reg;
        wcond[WB_VOUT_UVW] = wavg_reg[CH_VOUT] < uvw_out_reg;
        wcond[WB_IOUT_OCW] = wavg_reg[CH_IOUT] > ocw_reg;
        wcond[WB_TEMP_OTW] = wavg_reg[CH_TEMP] > otw_reg;
        wcond[WB_PIN_OPW] = wavg_reg[CH_PIN] > opw_reg;
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            warn_reg <= 16'h0000;
        end else begin
            warn_reg <= (clr_warn ? 16'h0000 : warn_reg) | wcond;
        end
    end

    // own alarm drive reads back low through the synchroniser; mask it
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            amask_reg <= ALARM_MASK_CYC;
        end else if (!alarm_oe_n_reg) begin
            amask_reg <= ALARM_MASK_CYC;
        end else if (amask_reg != 3'h0) begin
            amask_reg <= amask_reg - 3'h1;
        end
    end
    assign ext_alarm = !pin_q_reg[SI_ALARM] && alarm_oe_n_reg && amask_reg == 3'h0;

    always_comb begin
        det = 16'h0000;
        det[CB_SUOCP] = pin_q_reg[SI_SUOCP] && !pg;
        det[CB_SEVOCP] = pin_q_reg[SI_SEVOCP];
        det[CB_SAFEOCP] = pin_q_reg[SI_SAFEOCP];
        det[CB_FETSH] = pin_q_reg[SI_FETSH];
        det[CB_SSDIS] = pin_q_reg[SI_SSDIS];
        det[CB_ADDRR] = pin_q_reg[SI_ADDRR];
        det[CB_OCPR] = pin_q_reg[SI_OCPR];
        det[CB_BOOST] = pin_q_reg[SI_BOOST] && pg;
        det[CB_OVP] = pin_q_reg[SI_OVP] && prot_cfg_reg[PC_OVP_EN_BIT];
        det[CB_OTF] = wavg_reg[CH_TEMP] > otf_reg;
        det[CB_OPF] = wavg_reg[CH_PIN] > opf_reg;
        det[CB_EXT] = ext_alarm;
    end

    // lockout low never sets a cause, only clears them
    assign clear = !lockout_ok || restart;
    assign cause_next = (clear ? 16'h0000 : cause_reg) | det;
    assign boost_off_next = (clear ? 1'b0 : boost_off_reg) | (pin_q_reg[SI_BOOST] && !pg);

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cause_reg <= 16'h0000;
            boost_off_reg <= 1'b0;
            alarm_oe_n_reg <= 1'b1;
            sw_reg <= 1'b0;
        end else begin
            cause_reg <= cause_next;
            boost_off_reg <= boost_off_next;
            alarm_oe_n_reg <= !(|cause_next);
            sw_reg <= lockout_ok && !(|cause_next) && !boost_off_next;
        end
    end

    assign qual = pin_q_reg[SI_VOUTPG] && lockout_ok && !cause_reg[CB_FETSH]
        && sw_reg && pin_q_reg[SI_FETON];

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pg_cnt_reg <= 32'h0;
            okay_oe_n_reg <= 1'b0;
        end else if (!qual) begin
            pg_cnt_reg <= 32'h0;
            okay_oe_n_reg <= 1'b0;
        end else if (pg_cnt_reg == PG_DELAY_CYCLES - 1) begin
            okay_oe_n_reg <= 1'b1;
        end else begin
            pg_cnt_reg <= pg_cnt_reg + 32'h1;
        end
    end

    always_comb begin
        status = 16'h0000;
        status[ST_SW_ON] = sw_reg;
        status[ST_PG] = pg;
        status[ST_ALARM] = !alarm_oe_n_reg;
        // boost lockout before startup stays out of status
        status[ST_LOCKOUT_OK] = lockout_ok;
    end

    always_comb begin
        unique case (CMD_CODE)
            CMD_VOUT_UVW: rd_mux = uvw_out_reg;
            CMD_IOUT_OCW: rd_mux = ocw_reg;
            CMD_TEMP_OTF: rd_mux = otf_reg;
            CMD_TEMP_OTW: rd_mux = otw_reg;
            CMD_VIN_UVW: rd_mux = uvw_in_reg;
            CMD_VIN_UVF: rd_mux = uvf_in_reg;
            CMD_PIN_OPW: rd_mux = opw_reg;
            CMD_PROT_CFG: rd_mux = prot_cfg_reg;
            CMD_SU_CFG: rd_mux = su_cfg_reg;
            CMD_PIN_OPF: rd_mux = opf_reg;
            CMD_STATUS: rd_mux = status;
            CMD_READ_VIN: rd_mux = ravg_reg[CH_VIN];
            CMD_READ_VOUT: rd_mux = ravg_reg[CH_VOUT];
            CMD_READ_IOUT: rd_mux = ravg_reg[CH_IOUT];
            CMD_READ_TEMP: rd_mux = ravg_reg[CH_TEMP];
            CMD_READ_PIN: rd_mux = ravg_reg[CH_PIN];
            CMD_PEAK_BASE: rd_mux = peak_reg[CH_VIN];
            CMD_PEAK_BASE + 8'h1: rd_mux = peak_reg[CH_VOUT];
            CMD_PEAK_BASE + 8'h2: rd_mux = peak_reg[CH_IOUT];
            CMD_PEAK_BASE + 8'h3: rd_mux = peak_reg[CH_PIN];
            CMD_PEAK_BASE + 8'h4: rd_mux = peak_reg[CH_TEMP];
            CMD_EIN_LO: rd_mux = ein_reg[15:0];
            CMD_EIN_HI: rd_mux = ein_reg[31:16];
            CMD_CAUSE: rd_mux = cause_reg;
            CMD_WARN: rd_mux = warn_reg;
            default: rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rd_data_reg <= 16'h0000;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= RD_STB;
            if (RD_STB) begin
                rd_data_reg <= rd_mux;
            end
        end
    end

    assign RD_DATA = rd_data_reg;
    assign RD_VALID = rd_valid_reg;
    assign ALARM_OUT = 1'b0;
    assign ALARM_OE_N = alarm_oe_n_reg;
    assign SUPPLY_OK_PIN_OUT = 1'b0;
    assign SUPPLY_OK_PIN_OE_N = okay_oe_n_reg;
    assign SWITCH_EN = sw_reg;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);

    property p_sev;
        pin_q_reg[SI_SEVOCP] |=> cause_reg[CB_SEVOCP] && !ALARM_OE_N && !SWITCH_EN;
    endproperty
    a_sev: assert property (p_sev) else $error("severe overcurrent not latched");
    property p_fet;
        pin_q_reg[SI_FETSH] |=> cause_reg[CB_FETSH] ##1 !SUPPLY_OK_PIN_OE_N;
    endproperty
    a_fet: assert property (p_fet) else $error("switch short not handled");
    property p_lock;
        !lockout_ok && det == 16'h0000 |=> cause_reg == 16'h0000 && ALARM_OE_N
            && !SWITCH_EN && !SUPPLY_OK_PIN_OE_N;
    endproperty
    a_lock: assert property (p_lock) else $error("lockout did not clear");
    property p_boost;
        pin_q_reg[SI_BOOST] && !pg && det == 16'h0000 && cause_reg == 16'h0000
            |=> !SWITCH_EN && ALARM_OE_N && cause_reg == 16'h0000;
    endproperty
    a_boost: assert property (p_boost) else $error("boost lockout misreported");
    property p_pgq;
        SUPPLY_OK_PIN_OE_N |-> $past(qual);
    endproperty
    a_pgq: assert property (p_pgq) else $error("supply ok without conditions");
    property p_pgd;
        $rose(SUPPLY_OK_PIN_OE_N) |-> $past(pg_cnt_reg) == PG_DELAY_CYCLES - 1;
    endproperty
    a_pgd: assert property (p_pgd) else $error("supply ok delay wrong");
    property p_ein;
        SAMPLE_VALID |=> ein_reg == $past(ein_reg) + {16'h0000, $past(pwr_prod[31:16])};
    endproperty
    a_ein: assert property (p_ein) else $error("energy not accumulated");
    property p_peak;
        SAMPLE_VALID && VIN_SAMPLE > peak_reg[CH_VIN] |=> peak_reg[CH_VIN] == $past(VIN_SAMPLE);
    endproperty
    a_peak: assert property (p_peak) else $error("input peak not held");
    property p_warn;
        wcond[WB_TEMP_OTW] |=> warn_reg[WB_TEMP_OTW];
    endproperty
    a_warn: assert property (p_warn) else $error("warning flag missed");
    property p_ext;
        ext_alarm && lockout_ok && !restart |=> cause_reg[CB_EXT] && !ALARM_OE_N;
    endproperty
    a_ext: assert property (p_ext) else $error("external alarm not latched");
    property p_rst;
        restart && det == 16'h0000 && !pin_q_reg[SI_BOOST] |=> cause_reg == 16'h0000;
    endproperty
    a_rst: assert property (p_rst) else $error("restart did not clear");
    c_pg: cover property ($rose(SUPPLY_OK_PIN_OE_N));
    c_alarm: cover property ($fell(ALARM_OE_N));
    c_restart: cover property (restart && cause_reg != 16'h0000);
endmodule : fsup_top

// ==== common/fsup_pkg.sv ====
// command codes, field positions, reset values and timing for the fault supervisor
package fsup_pkg;
    // command codes, documented limits and configuration
    localparam logic [7:0] CMD_VOUT_UVW = 8'h43;
    localparam logic [7:0] CMD_IOUT_OCW = 8'h4a;
    localparam logic [7:0] CMD_TEMP_OTF = 8'h4f;
    localparam logic [7:0] CMD_TEMP_OTW = 8'h51;
    localparam logic [7:0] CMD_VIN_UVW = 8'h58;
    localparam logic [7:0] CMD_VIN_UVF = 8'h59;
    localparam logic [7:0] CMD_PIN_OPW = 8'h6b;
    localparam logic [7:0] CMD_PROT_CFG = 8'hd0;
    localparam logic [7:0] CMD_SU_CFG = 8'hdd;
    localparam logic [7:0] CMD_PIN_OPF = 8'hf5;
    // command codes, control and readback
    localparam logic [7:0] CMD_OPERATION = 8'h01;
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_STATUS = 8'h79;
    localparam logic [7:0] CMD_READ_VIN = 8'h88;
    localparam logic [7:0] CMD_READ_VOUT = 8'h8b;
    localparam logic [7:0] CMD_READ_IOUT = 8'h8c;
    localparam logic [7:0] CMD_READ_TEMP = 8'h8d;
    localparam logic [7:0] CMD_READ_PIN = 8'h97;
    localparam logic [7:0] CMD_PEAK_BASE = 8'he0;
    localparam logic [7:0] CMD_EIN_LO = 8'he6;
    localparam logic [7:0] CMD_EIN_HI = 8'he7;
    localparam logic [7:0] CMD_CAUSE = 8'he8;
    localparam logic [7:0] CMD_WARN = 8'he9;
    // field positions
    localparam int OP_RESTART_BIT = 7;
    localparam int PC_WAVG_LSB = 0;
    localparam int PC_OVP_SEL_LSB = 2;
    localparam int PC_OVP_EN_BIT = 4;
    localparam int PC_PG_SEL_LSB = 8;
    localparam int SC_RAVG_LSB = 0;
    localparam int SC_SUOCP_LSB = 4;
    // reset values
    localparam logic [15:0] LIM_LOW_RST = 16'h0000;
    localparam logic [15:0] LIM_HIGH_RST = 16'hffff;
    localparam logic [15:0] CFG_RST = 16'h0000;
    // timing
    localparam int PG_DELAY_MS = 5;
    localparam int CLK_KHZ = 50000;
    localparam logic [2:0] ALARM_MASK_CYC = 3'h5;
    // telemetry channels
    localparam int CH_VIN = 0;
    localparam int CH_VOUT = 1;
    localparam int CH_IOUT = 2;
    localparam int CH_PIN = 3;
    localparam int CH_TEMP = 4;
    localparam int NUM_CH = 5;
    // synchronised pin inputs
    localparam int SI_SUOCP = 0;
    localparam int SI_SEVOCP = 1;
    localparam int SI_SAFEOCP = 2;
    localparam int SI_FETSH = 3;
    localparam int SI_SSDIS = 4;
    localparam int SI_ADDRR = 5;
    localparam int SI_OCPR = 6;
    localparam int SI_BOOST = 7;
    localparam int SI_OVP = 8;
    localparam int SI_ENLO = 9;
    localparam int SI_VOUTPG = 10;
    localparam int SI_FETON = 11;
    localparam int SI_ALARM = 12;
    localparam int NUM_SI = 13;
    localparam logic [12:0] PIN_Q_RST = 13'h1000;
    // latched fault cause bits
    localparam int CB_SUOCP = 0;
    localparam int CB_SEVOCP = 1;
    localparam int CB_SAFEOCP = 2;
    localparam int CB_FETSH = 3;
    localparam int CB_SSDIS = 4;
    localparam int CB_ADDRR = 5;
    localparam int CB_OCPR = 6;
    localparam int CB_BOOST = 7;
    localparam int CB_OVP = 8;
    localparam int CB_OTF = 9;
    localparam int CB_OPF = 10;
    localparam int CB_EXT = 11;
    // warning bits
    localparam int WB_VIN_UVW = 0;
    localparam int WB_VIN_UVF = 1;
    localparam int WB_VOUT_UVW = 2;
    localparam int WB_IOUT_OCW = 3;
    localparam int WB_TEMP_OTW = 4;
    localparam int WB_PIN_OPW = 5;
    // status bits
    localparam int ST_SW_ON = 0;
    localparam int ST_PG = 1;
    localparam int ST_ALARM = 2;
    localparam int ST_BOOST_OFF = 3;
    localparam int ST_LOCKOUT_OK = 4;
endpackage : fsup_pkg

// ==== verif/fsup_host.sv ====
// host model driving the command port
`timescale 1ns/1ps
module fsup_host (
    // clock
    input wire logic clk,
    // command port
    output logic [7:0] code,
    output logic wr_stb,
    output logic [15:0] wr_data,
    output logic rd_stb,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid
);
    initial {code, wr_stb, wr_data, rd_stb} = '0;
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(negedge clk) {code, wr_data, wr_stb} = {c, d, 1'b1};
        // released data is inverted so a stale value never looks valid
        @(negedge clk) {wr_data, wr_stb} = {~d, 1'b0};
    endtask : wr
    task automatic rd(input logic [7:0] c, output logic [15:0] d);
        @(negedge clk) {code, rd_stb} = {c, 1'b1};
        @(negedge clk) rd_stb = 1'b0;
        d = rd_valid ? rd_data : 'x;
    endtask : rd
endmodule : fsup_host

// ==== verif/fault_supervisor_telemetry_tb_top.sv ====
// self-checking bench for the fault supervisor
`timescale 1ns/1ps
module fault_supervisor_telemetry_tb_top;
    import fsup_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [11:0] det = 12'h200;
    logic sv = 1'b0;
    logic [15:0] vin = '0, vout = '0, iout = '0, temp = '0, wd, rdd, d;
    logic [7:0] code;
    logic wr, rd, rv, oe_n, ok_oe_n, sw, ao, so;
    logic pull_n = 1'b1;
    logic [1:0] su_sel, ov_sel, pg_sel;
    int mismatches = 0, num_checks = 0, cyc = 0;
    always #10 clk = ~clk;
    fsup_host i_host (.clk(clk), .code(code), .wr_stb(wr), .wr_data(wd), .rd_stb(rd),
        .rd_data(rdd), .rd_valid(rv));
    // alarm wire has a pull-up; pull_n low stands for an outside puller
    fsup_top #(.PG_DELAY_CYCLES(20)) i_dut (.REF_CLK(clk), .ARST_N(arst_n),
        .STARTUP_OCP_DET(det[0]), .SEVERE_OCP_DET(det[1]), .SAFE_OCP_DET(det[2]),
        .FET_SHORT_DET(det[3]), .SOFTSTART_CAP_FAIL(det[4]), .BUS_ADDRESS_RESISTOR_BAD(det[5]),
        .OVERCURRENT_SET_RESISTOR_BAD(det[6]), .BOOST_SUPPLY_LOCKOUT(det[7]),
        .INPUT_OVERVOLT_TRIP(det[8]), .ENABLE_LOCKOUT_PIN(det[9]), .VOUT_ABOVE_PG(det[10]),
        .FET_FULLY_ON(det[11]), .ALARM_IN(oe_n & pull_n), .ALARM_OUT(ao), .ALARM_OE_N(oe_n),
        .SUPPLY_OK_PIN_OUT(so), .SUPPLY_OK_PIN_OE_N(ok_oe_n), .SWITCH_EN(sw),
        .STARTUP_OCP_SEL(su_sel), .OVP_SEL(ov_sel), .PG_THRESH_SEL(pg_sel),
        .SAMPLE_VALID(sv), .VIN_SAMPLE(vin), .VOUT_SAMPLE(vout), .IOUT_SAMPLE(iout),
        .TEMP_SAMPLE(temp), .CMD_CODE(code), .WR_STB(wr), .WR_DATA(wd), .RD_STB(rd),
        .RD_DATA(rdd), .RD_VALID(rv));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic rdc(input logic [7:0] c, input logic [15:0] e);
        i_host.rd(c, d);
        chk($sformatf("cmd %h", c), e, d);
    endtask : rdc
    task automatic cy(input int n);
        repeat (n) @(negedge clk);
    endtask : cy
    // pulse one detector, then let it clear through the sync chain
    task automatic hit(input int i);
        det[i] = 1'b1;
        cy(8);
        det[i] = 1'b0;
        cy(5);
    endtask : hit
    task automatic t_regs;
        rdc(CMD_TEMP_OTF, LIM_HIGH_RST);
        rdc(CMD_VIN_UVF, LIM_LOW_RST);
        i_host.wr(CMD_PIN_OPF, 16'h1357);
        rdc(CMD_PIN_OPF, 16'h1357);
        i_host.wr(CMD_SU_CFG, 16'h0020);
        i_host.wr(CMD_PROT_CFG, 16'h030c);
        chk("trims", 16'h002f, {su_sel, ov_sel, pg_sel});
        chk("od data", 16'h0, {ao, so});
    endtask : t_regs
    task automatic t_fault;
        for (int i = 0; i < 7; i++) begin
            hit(i);
            chk("alarm sw", 16'h0, {oe_n, sw});
            rdc(CMD_CAUSE, 16'h1 << i);
            i_host.wr(CMD_OPERATION, 16'h0080);
            cy(3);
            chk("alarm", 16'h1, oe_n);
        end
        i_host.wr(CMD_PROT_CFG, 16'h031c);
        hit(8);
        rdc(CMD_CAUSE, 16'h0100);
        i_host.wr(CMD_OPERATION, 16'h0080);
        i_host.wr(CMD_PROT_CFG, 16'h030c);
        hit(8);
        chk("ovp off", 16'h1, oe_n);
    endtask : t_fault
    task automatic t_lock;
        hit(1);
        det[9] = 1'b0;
        cy(8);
        chk("alarm", 16'h1, oe_n);
        rdc(CMD_CAUSE, 16'h0);
        det[9] = 1'b1;
        cy(8);
        hit(7);
        chk("alarm sw", 16'h2, {oe_n, sw});
        rdc(CMD_CAUSE, 16'h0);
        rdc(CMD_STATUS, 16'h0010);
        i_host.wr(CMD_OPERATION, 16'h0080);
        pull_n = 1'b0;
        cy(8);
        pull_n = 1'b1;
        cy(3);
        chk("ext alarm", 16'h0, oe_n);
        rdc(CMD_CAUSE, 16'h0800);
        i_host.wr(CMD_OPERATION, 16'h0080);
        cy(8);
        chk("alarm", 16'h1, oe_n);
    endtask : t_lock
    task automatic t_pg;
        det[11:10] = 2'b11;
        cy(20);
        chk("pg early", 16'h0, ok_oe_n);
        cy(10);
        chk("pg", 16'h1, ok_oe_n);
        det[11] = 1'b0;
        cy(6);
        chk("pg drop", 16'h0, ok_oe_n);
    endtask : t_pg
    task automatic smp_pulse;
        sv = 1'b1;
        cy(1);
        sv = 1'b0;
        cy(4);
    endtask : smp_pulse
    task automatic t_tele;
        i_host.wr(CMD_TEMP_OTW, 16'h0010);
        {vin, vout, iout, temp} = {16'h1234, 16'h0456, 16'h2000, 16'h0020};
        smp_pulse;
        rdc(CMD_PEAK_BASE, 16'h1234);
        rdc(CMD_PEAK_BASE + 8'h1, 16'h0456);
        rdc(CMD_READ_PIN, 16'h0246);
        rdc(CMD_EIN_LO, 16'h0246);
        rdc(CMD_EIN_HI, 16'h0000);
        rdc(CMD_READ_TEMP, 16'h0020);
        rdc(CMD_WARN, 16'h0010);
        // two-sample reports while warnings still average one sample
        i_host.wr(CMD_SU_CFG, 16'h0021);
        temp = 16'h0040;
        smp_pulse;
        rdc(CMD_READ_TEMP, 16'h0020);
        smp_pulse;
        rdc(CMD_READ_TEMP, 16'h0040);
    endtask : t_tele
    task automatic complete_run;
        if (mismatches == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run
    initial begin
        cy(5);
        arst_n = 1'b1;
        cy(6);
        t_regs;
        t_fault;
        t_lock;
        t_pg;
        t_tele;
        complete_run;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            mismatches++;
            complete_run;
        end
    end
endmodule : fault_supervisor_telemetry_tb_top
